// ==== src/relay_pkg.sv ====
package relay_pkg;

    // number of assignable source signals
    localparam int unsigned NUM_SRC       = 7;

    // clock and timer resolution, times in seconds
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam real         TIME_RES_S    = 0.01;
    localparam real         TIME_MAX_S    = 300.00;
    localparam real         TIME_RESET_S  = 0.00;
    localparam int unsigned TICK_CYCLES   = int'(TIME_RES_S * real'(CLK_HZ));

    // time settings held as counts of 0.01 s ticks
    localparam logic [15:0] TIME_MAX      = 16'(int'(TIME_MAX_S / TIME_RES_S));
    localparam logic [15:0] TIME_RESET    = 16'(int'(TIME_RESET_S / TIME_RES_S));

    // register offsets (byte addresses)
    localparam logic [3:0]  CTRL_OFS      = 4'h0;
    localparam logic [3:0]  HOLD_OFS      = 4'h4;
    localparam logic [3:0]  OFF_DLY_OFS   = 4'h8;
    localparam logic [3:0]  STATUS_OFS    = 4'hC;

    // control register field positions
    localparam int unsigned AMASK_LSB     = 0;
    localparam int unsigned IMASK_LSB     = 8;
    localparam int unsigned OINV_BIT      = 16;
    localparam int unsigned LATCH_BIT     = 17;
    localparam int unsigned ACK_EN_BIT    = 18;
    localparam int unsigned CLOSED_BIT    = 19;

    // status register field positions
    localparam int unsigned ST_COLL_BIT   = 0;
    localparam int unsigned ST_DLY_BIT    = 1;
    localparam int unsigned ST_LATCH_BIT  = 2;
    localparam int unsigned ST_OUT_BIT    = 3;
    localparam int unsigned ST_DRIVE_BIT  = 4;
    localparam int unsigned ST_HOLD_BIT   = 5;

    // control values after reset
    localparam logic [6:0]  AMASK_RESET   = 7'h01;
    localparam logic [6:0]  IMASK_RESET   = 7'h00;
    localparam logic        OINV_RESET    = 1'h0;
    localparam logic        LATCH_RESET   = 1'h0;
    localparam logic        ACK_EN_RESET  = 1'h0;
    localparam logic        CLOSED_RESET  = 1'h0;

endpackage

// ==== src/tick_gen.sv ====
`timescale 1ns/1ps

module tick_gen
#(
    parameter int unsigned COUNT = relay_pkg::TICK_CYCLES
)
(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic reset_in,
    // one-cycle enable every COUNT cycles
    output logic      tick_out
);

    localparam int unsigned W = (COUNT > 1) ? $clog2(COUNT) : 1;

    typedef struct packed
    {
        logic [W-1:0] cnt;
        logic         tick;
    } tick_state_type;

    tick_state_type st_r;
    tick_state_type st_nxt;

    // free running divider, wraps at COUNT-1
    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.tick = 1'h0;
        if (st_r.cnt >= W'(COUNT - 1))
        begin
            st_nxt.cnt  = '0;
            st_nxt.tick = 1'h1;
        end
        else
        begin
            st_nxt.cnt = st_r.cnt + W'(1);
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign tick_out = st_r.tick;

endmodule

// ==== src/relay_output_conditioner.sv ====
// Operation
// R1: output is OR of assigned sources
// R2: each source individually invertible, default off
// R3: optional inversion of combined result
// R4: minimum hold time and switch-off delay
// R5: latch keeps output after pick-up
// R6: acknowledge input releases the latch
// R7: acknowledge ignored while latching disabled
// R8: operating mode selects relay drive polarity
`timescale 1ns/1ps

module relay_output_conditioner
#(
    parameter int unsigned TICK_CYCLES = relay_pkg::TICK_CYCLES
)
(
    // clock and reset
    input  wire logic                         CLK_IN,
    input  wire logic                         RESET_IN,
    // register port
    input  wire logic [3:0]                   ADDR_IN,
    input  wire logic [31:0]                  WDATA_IN,
    input  wire logic                         WR_IN,
    input  wire logic                         RD_IN,
    output logic      [31:0]                  RDATA_OUT,
    // protection signals and acknowledge
    input  wire logic [relay_pkg::NUM_SRC-1:0] SRC_IN,
    input  wire logic                         ACK_IN,
    // relay coil drive and state
    output logic                              RELAY_OUT,
    output logic                              LATCHED_OUT
);

    typedef struct packed
    {
        logic [relay_pkg::NUM_SRC-1:0] amask;
        logic [relay_pkg::NUM_SRC-1:0] imask;
        logic                          oinv;
        logic                          latch_en;
        logic                          ack_en;
        logic                          closed;
        logic [15:0]                   hold_t;
        logic [15:0]                   off_dly;
        logic [15:0]                   hold_cnt;
        logic [15:0]                   off_cnt;
        logic                          dly;
        logic                          latched;
        logic                          outp;
        logic                          drive;
        logic [31:0]                   rdata;
    } state_type;

    state_type                     st_r;
    state_type                     st_nxt;
    logic                          tick;
    logic [relay_pkg::NUM_SRC-1:0] gated;
    logic                          coll;
    logic                          hold_busy;

    // settings above the range are clamped, not wrapped
    function automatic logic [15:0] clamp_time(input logic [31:0] v);
        if (v > {16'h0000, relay_pkg::TIME_MAX})
            clamp_time = relay_pkg::TIME_MAX;
        else
            clamp_time = v[15:0];
    endfunction

    // 0.01 s timer tick
    tick_gen #(
        .COUNT    (TICK_CYCLES)
    ) u_tick (
        .clk_in   (CLK_IN),
        .reset_in (RESET_IN),
        .tick_out (tick)
    );

    // per-source inversion and assignment gate
    genvar i;
    generate
        for (i = 0; i < relay_pkg::NUM_SRC; i++)
        begin : g_src
            // R2: optional input inversion
            assign gated[i] = st_r.amask[i] & (SRC_IN[i] ^ st_r.imask[i]);
        end
    endgenerate

    // R1: or of assigned
    // R3: result inversion
    assign coll = (|gated) ^ st_r.oinv;

    // R4: hold window open
    assign hold_busy = (st_r.hold_t != 16'h0000) && (st_r.hold_cnt <= st_r.hold_t);

    // next state: registers, timers, latch, output
    always_comb
    begin
        logic demand;
        demand = 1'h0;
        st_nxt = st_r;

        // register writes
        if (WR_IN)
        begin
            case (ADDR_IN)
                relay_pkg::CTRL_OFS:
                begin
                    st_nxt.amask    = WDATA_IN[relay_pkg::AMASK_LSB +: relay_pkg::NUM_SRC];
                    st_nxt.imask    = WDATA_IN[relay_pkg::IMASK_LSB +: relay_pkg::NUM_SRC];
                    st_nxt.oinv     = WDATA_IN[relay_pkg::OINV_BIT];
                    st_nxt.latch_en = WDATA_IN[relay_pkg::LATCH_BIT];
                    // R7: ack selectable only when latching
                    st_nxt.ack_en   = WDATA_IN[relay_pkg::ACK_EN_BIT] & WDATA_IN[relay_pkg::LATCH_BIT];
                    st_nxt.closed   = WDATA_IN[relay_pkg::CLOSED_BIT];
                end
                relay_pkg::HOLD_OFS:    st_nxt.hold_t  = clamp_time(WDATA_IN);
                relay_pkg::OFF_DLY_OFS: st_nxt.off_dly = clamp_time(WDATA_IN);
                default:                st_nxt.rdata   = st_r.rdata;
            endcase
        end

        // register reads, data valid only in the following cycle
        st_nxt.rdata = 32'h0000_0000;
        if (RD_IN)
        begin
            case (ADDR_IN)
                relay_pkg::CTRL_OFS:
                begin
                    st_nxt.rdata[relay_pkg::AMASK_LSB +: relay_pkg::NUM_SRC] = st_r.amask;
                    st_nxt.rdata[relay_pkg::IMASK_LSB +: relay_pkg::NUM_SRC] = st_r.imask;
                    st_nxt.rdata[relay_pkg::OINV_BIT]                        = st_r.oinv;
                    st_nxt.rdata[relay_pkg::LATCH_BIT]                       = st_r.latch_en;
                    st_nxt.rdata[relay_pkg::ACK_EN_BIT]                      = st_r.ack_en;
                    st_nxt.rdata[relay_pkg::CLOSED_BIT]                      = st_r.closed;
                end
                relay_pkg::HOLD_OFS:    st_nxt.rdata[15:0] = st_r.hold_t;
                relay_pkg::OFF_DLY_OFS: st_nxt.rdata[15:0] = st_r.off_dly;
                relay_pkg::STATUS_OFS:
                begin
                    st_nxt.rdata[relay_pkg::ST_COLL_BIT]  = coll;
                    st_nxt.rdata[relay_pkg::ST_DLY_BIT]   = st_r.dly;
                    st_nxt.rdata[relay_pkg::ST_LATCH_BIT] = st_r.latched;
                    st_nxt.rdata[relay_pkg::ST_OUT_BIT]   = st_r.outp;
                    st_nxt.rdata[relay_pkg::ST_DRIVE_BIT] = st_r.drive;
                    st_nxt.rdata[relay_pkg::ST_HOLD_BIT]  = hold_busy;
                end
                default:                st_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // R4: switch-off delay
        if (coll)
        begin
            st_nxt.dly     = 1'h1;
            st_nxt.off_cnt = 16'h0000;
        end
        else if (st_r.dly)
        begin
            // first tick may be early, so count one past the setting
            if ((st_r.off_dly == 16'h0000) || (st_r.off_cnt > st_r.off_dly))
                st_nxt.dly = 1'h0;
            else if (tick)
                st_nxt.off_cnt = st_r.off_cnt + 16'h0001;
        end

        // R5: latch on pick-up
        // R6: ack releases latch
        // R7: no latch, no ack
        // a pick-up in the ack cycle wins over the release
        st_nxt.latched = st_nxt.latch_en & ((st_r.latched & ~(ACK_IN & st_r.ack_en)) | st_nxt.dly);
        if (!st_nxt.latch_en)
            st_nxt.ack_en = 1'h0;

        demand = st_nxt.dly | st_nxt.latched;

        // R4: minimum hold time
        if ((demand != st_r.outp) && !hold_busy)
        begin
            st_nxt.outp     = demand;
            st_nxt.hold_cnt = 16'h0000;
        end
        else if (tick && (st_r.hold_cnt <= relay_pkg::TIME_MAX))
        begin
            // ages even with hold off, so a later setting sees how old the state is
            st_nxt.hold_cnt = st_r.hold_cnt + 16'h0001;
        end

        // R8: coil polarity
        st_nxt.drive = st_nxt.outp ^ st_nxt.closed;
    end

    // state register, settings return to defaults on reset
    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
        begin
            st_r          <= '0;
            st_r.amask    <= relay_pkg::AMASK_RESET;
            st_r.imask    <= relay_pkg::IMASK_RESET;
            st_r.oinv     <= relay_pkg::OINV_RESET;
            st_r.latch_en <= relay_pkg::LATCH_RESET;
            st_r.ack_en   <= relay_pkg::ACK_EN_RESET;
            st_r.closed   <= relay_pkg::CLOSED_RESET;
            st_r.hold_t   <= relay_pkg::TIME_RESET;
            st_r.off_dly  <= relay_pkg::TIME_RESET;
            st_r.drive    <= relay_pkg::CLOSED_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flip-flops
    assign RDATA_OUT   = st_r.rdata;
    assign RELAY_OUT   = st_r.drive;
    assign LATCHED_OUT = st_r.latched;

    // checks, all on the one clock
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (RESET_IN);

    property p_or_unassigned;
        (st_r.amask == 7'h00) && !st_r.oinv |-> !coll;
    endproperty
    a_or_unassigned: assert property (p_or_unassigned) else $error("unassigned sources set output"); // R1

    property p_inv_input;
        (st_r.amask == 7'h01) && st_r.imask[0] && !st_r.oinv && !SRC_IN[0] |-> coll;
    endproperty
    a_inv_input: assert property (p_inv_input) else $error("inverted input not honoured"); // R2

    property p_out_inv;
        (st_r.amask == 7'h00) && st_r.oinv |-> coll;
    endproperty
    a_out_inv: assert property (p_out_inv) else $error("result inversion not honoured"); // R3

    property p_hold;
        hold_busy |=> $stable(st_r.outp);
    endproperty
    a_hold: assert property (p_hold) else $error("output changed inside hold time"); // R4

    property p_off_delay;
        $fell(st_r.dly) |-> ($past(st_r.off_dly) == 16'h0000) || ($past(st_r.off_cnt) > $past(st_r.off_dly));
    endproperty
    a_off_delay: assert property (p_off_delay) else $error("switch-off before delay expired"); // R4

    property p_latch_keep;
        st_r.latched && st_r.latch_en && !ACK_IN && !WR_IN |=> st_r.latched;
    endproperty
    a_latch_keep: assert property (p_latch_keep) else $error("latch dropped without ack"); // R5

    property p_ack_release;
        st_r.latched && st_r.ack_en && ACK_IN && !coll && !st_r.dly |=> !st_r.latched;
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("ack did not release latch"); // R6

    property p_ack_ignored;
        !st_r.latch_en |-> !st_r.ack_en && !st_r.latched;
    endproperty
    a_ack_ignored: assert property (p_ack_ignored) else $error("ack or latch active while latching off"); // R7

    property p_drive;
        $changed(st_r.outp) && $stable(st_r.closed) |-> $changed(RELAY_OUT) && (RELAY_OUT == (st_r.outp ^ st_r.closed));
    endproperty
    a_drive: assert property (p_drive) else $error("relay drive polarity wrong"); // R8

endmodule

// ==== bench/relay_far_side.sv ====
`timescale 1ns/1ps

module relay_far_side
(
    // clock
    input  wire logic                          clk_in,
    // commanded protection levels
    input  wire logic [relay_pkg::NUM_SRC-1:0] src_cmd_in,
    input  wire logic                          ack_cmd_in,
    // levels seen by the relay block
    output logic      [relay_pkg::NUM_SRC-1:0] src_out,
    output logic                               ack_out,
    // coil drive and pick-up count
    input  wire logic                          coil_in,
    output int                                 pickups_out
);
    logic coil_r  = 1'b0;
    int   count_r = 0;

    // protection signals are plain levels, so they pass straight through
    assign src_out = src_cmd_in;
    assign ack_out = ack_cmd_in;

    // coil counts energise edges, a crude contact wear record
    always @(posedge clk_in)
    begin
        if (coil_in && !coil_r)
            count_r <= count_r + 1;
        coil_r <= coil_in;
    end

    assign pickups_out = count_r;
endmodule

// ==== bench/relay_output_conditioner_test.sv ====
`timescale 1ns/1ps

module relay_output_conditioner_test;
    typedef struct packed {logic [31:0] ctrl; logic [6:0] src; logic relay;} row_type;
    // small tick keeps the timer scenarios short
    localparam int TCK = 4;
    localparam row_type ROWS [10] = '{
        '{32'h00001, 7'h01, 1'b1}, '{32'h00001, 7'h02, 1'b0}, '{32'h0007F, 7'h40, 1'b1},
        '{32'h0007F, 7'h00, 1'b0}, '{32'h00101, 7'h00, 1'b1}, '{32'h00200, 7'h00, 1'b0},
        '{32'h10003, 7'h01, 1'b0}, '{32'h10303, 7'h03, 1'b1}, '{32'h10303, 7'h01, 1'b0},
        '{32'h80001, 7'h01, 1'b0}};
    logic        clk   = 1'b0;
    logic        rst   = 1'b1;
    logic [3:0]  addr  = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic [31:0] rdata;
    logic [6:0]  src_cmd = 7'h00;
    logic        ack_cmd = 1'b0;
    logic [6:0]  src;
    logic        ack;
    logic        relay;
    logic        latched;
    logic [31:0] rv;
    int          pickups;
    int          n_errors = 0;
    int          total_checks = 0;

    // 50 MHz clock
    always #10 clk = ~clk;

    relay_output_conditioner #(.TICK_CYCLES(TCK)) i_dut (
        .CLK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
        .RDATA_OUT(rdata), .SRC_IN(src), .ACK_IN(ack), .RELAY_OUT(relay), .LATCHED_OUT(latched));

    relay_far_side i_far (
        .clk_in(clk), .src_cmd_in(src_cmd), .ack_cmd_in(ack_cmd), .src_out(src), .ack_out(ack),
        .coil_in(relay), .pickups_out(pickups));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // edges, then step off the edge so outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic drive(input logic [6:0] s, input logic a);
        @(posedge clk);
        src_cmd <= s;
        ack_cmd <= a;
    endtask

    // watchdog, far beyond the expected run of a few hundred cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end

    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        check(relay, 0);
        check(latched, 0);
        rd_reg(4'h0, rv);
        check(rv, 32'h00001);
        rd_reg(4'h4, rv);
        check(rv, 32'h0);
        rd_reg(4'h8, rv);
        check(rv, 32'h0);
        rd_reg(4'h2, rv);
        check(rv, 32'h0);
        // read data must fall back to zero after its one cycle
        rd_reg(4'h0, rv);
        check(rv, 32'h00001);
        cyc(1);
        check(rdata, 32'h0);
        // table of combining and polarity cases, timers at zero
        foreach (ROWS[i])
        begin
            wr_reg(4'h0, ROWS[i].ctrl);
            drive(ROWS[i].src, 1'b0);
            cyc(3);
            check(relay, ROWS[i].relay);
        end
        drive(7'h00, 1'b0);
        cyc(3);
        check(relay, 1);
        // time settings saturate at the top of the range
        wr_reg(4'h0, 32'h00001);
        wr_reg(4'h4, 32'h0000FFFF);
        rd_reg(4'h4, rv);
        check(rv, 32'h00007530);
        // switch-off delay of three ticks
        wr_reg(4'h4, 32'h0);
        wr_reg(4'h8, 32'h3);
        drive(7'h01, 1'b0);
        cyc(3);
        check(relay, 1);
        drive(7'h00, 1'b0);
        cyc(10);
        check(relay, 1);
        cyc(10);
        check(relay, 0);
        // hold of two ticks against a short pulse
        wr_reg(4'h8, 32'h0);
        wr_reg(4'h4, 32'h2);
        // let the previous state age past the new hold first
        cyc(16);
        drive(7'h01, 1'b0);
        cyc(2);
        drive(7'h00, 1'b0);
        cyc(4);
        check(relay, 1);
        cyc(12);
        check(relay, 0);
        wr_reg(4'h4, 32'h0);
        // latch with acknowledge enabled
        wr_reg(4'h0, 32'h60001);
        drive(7'h01, 1'b0);
        drive(7'h00, 1'b0);
        cyc(3);
        check({latched, relay}, 2'b11);
        // status: latched, output and drive set, collective low
        rd_reg(4'hC, rv);
        check(rv, 32'h0000001C);
        drive(7'h01, 1'b1);
        drive(7'h00, 1'b0);
        cyc(3);
        check(latched, 1);
        drive(7'h00, 1'b1);
        drive(7'h00, 1'b0);
        cyc(3);
        check({latched, relay}, 2'b00);
        // acknowledge enable needs latch in the same write
        wr_reg(4'h0, 32'h40001);
        rd_reg(4'h0, rv);
        check(rv, 32'h00001);
        wr_reg(4'h0, 32'h20001);
        drive(7'h01, 1'b0);
        drive(7'h00, 1'b1);
        drive(7'h00, 1'b0);
        cyc(3);
        check({latched, relay}, 2'b11);
        // reset in mid-run drops the latch and restores defaults
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        check({latched, relay}, 2'b00);
        rd_reg(4'h0, rv);
        check(rv, 32'h00001);
        check(pickups != 0, 1);
        report_and_stop();
    end
endmodule
